// file: config_power_irq_regs.vh
// register offsets, reset values and bit positions of the configuration block
`ifndef CONFIG_POWER_IRQ_REGS_VH
`define CONFIG_POWER_IRQ_REGS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_SERIAL_PORT_MODE   7'h00
`define OFS_POWER_DOWN_CONTROL 7'h01
`define OFS_IRQ_ENABLE_LOW     7'h03
`define OFS_IRQ_ENABLE_HIGH    7'h04
`define OFS_IRQ_STATUS_LOW     7'h05
`define OFS_IRQ_STATUS_HIGH    7'h06

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_SERIAL_PORT_MODE   8'h81
`define RST_POWER_DOWN_CONTROL 8'h48
`define RST_IRQ_ENABLE         8'h00
`define RST_IRQ_STATUS         8'h00

// ---------------------------------------------------------------
// writable and live bit masks
// ---------------------------------------------------------------
`define MASK_ENABLE_LOW        8'hef
`define MASK_ENABLE_HIGH       8'hfc
`define MASK_STATUS_LOW        8'hef
`define MASK_STATUS_HIGH       8'h7c

// ---------------------------------------------------------------
// mode register bits
// ---------------------------------------------------------------
`define BIT_THREE_WIRE         7
`define BIT_LSB_FIRST          6
`define BIT_CONFIG_SELF_CLEAR  5
`define BIT_SHORT_ADDR         4

// ---------------------------------------------------------------
// power control bits
// ---------------------------------------------------------------
`define BIT_BANDGAP_OFF        7
`define BIT_REF_CURRENT_OFF    6
`define BIT_BIAS_CURRENTS_OFF  5
`define BIT_CONV_CLOCK_OFF     2
`define BIT_RETIMER_PLL_OFF    1
`define BIT_RX_DLL_OFF         0

// ---------------------------------------------------------------
// serial frame layout
// ---------------------------------------------------------------
`define BIT_READ_FLAG          7
`define FRAME_LAST_INSTR_BIT   4'd7
`define FRAME_FIRST_DATA_BIT   4'd8
`define FRAME_LAST_DATA_BIT    4'd15

`endif

// file: pin_sync.v
// three-stage synchroniser with agreement filter for outside signals
`timescale 1ns/1ps
`default_nettype none

module pin_sync
#(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)
(
    // clock and reset
    input  wire             clk,
    input  wire             reset,
    // signals
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_q
);

    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;
    reg [WIDTH-1:0] stage3_q;
    integer i;

    always @(posedge clk)
    begin
        if (reset)
        begin
            stage1_q <= INIT;
            stage2_q <= INIT;
            stage3_q <= INIT;
            sync_q   <= INIT;
        end
        else
        begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            for (i = 0; i < WIDTH; i = i + 1)
            begin
                if (stage2_q[i] == stage3_q[i])
                    sync_q[i] <= stage3_q[i];
            end
        end
    end

endmodule

`default_nettype wire

// file: sticky_flags.v
// bank of sticky status flags, set by events, cleared by writing one
`timescale 1ns/1ps
`default_nettype none

module sticky_flags
#(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] LIVE = {WIDTH{1'b1}}
)
(
    // clock and reset
    input  wire             clk,
    input  wire             reset,
    // control
    input  wire             clear_all,
    input  wire [WIDTH-1:0] set_pulse,
    input  wire [WIDTH-1:0] clear_pulse,
    // state
    output reg  [WIDTH-1:0] flags_q
);

    // a set in the same cycle as its clear wins
    always @(posedge clk)
    begin
        if (reset || clear_all)
            flags_q <= {WIDTH{1'b0}};
        else
            flags_q <= ((flags_q & ~clear_pulse) | set_pulse) & LIVE;
    end

endmodule

`default_nettype wire

// file: config_power_irq_regs.v
// serial-port configuration, power-down and interrupt register block
`timescale 1ns/1ps
`default_nettype none
`include "config_power_irq_regs.vh"

module config_power_irq_regs
#(
    parameter CUR_WIDTH = 10
)
(
    // clock and reset
    input  wire                 clk,
    input  wire                 reset,
    // serial port pins
    input  wire                 sclk,
    input  wire                 chip_select_n,
    input  wire                 sdi,
    input  wire                 sio_in,
    output reg                  sio_out,
    output wire                 sio_oe,
    output reg                  sdo,
    // event sources
    input  wire                 fifo_two_slot_warning,
    input  wire                 fifo_one_slot_warning,
    input  wire                 serial_frame_acknowledge,
    input  wire                 rx_dll_warning,
    input  wire                 rx_dll_lock,
    input  wire                 retimer_pll_lock,
    input  wire                 auto_pattern_compare_pass,
    input  wire                 auto_pattern_compare_fail,
    input  wire                 sample_pattern_compare_fail,
    input  wire                 parity_error_falling,
    input  wire                 parity_error_rising,
    // full-scale current path
    input  wire [CUR_WIDTH-1:0] full_scale_current,
    output reg  [CUR_WIDTH-1:0] full_scale_current_out,
    // power-down controls
    output wire                 bandgap_off,
    output wire                 ref_current_off,
    output wire                 bias_currents_off,
    output wire                 conv_clock_path_off,
    output wire                 retimer_pll_off,
    output wire                 rx_dll_off,
    // serial port mode
    output wire                 three_wire_mode,
    output wire                 lsb_first,
    // interrupt request
    output reg                  irq
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    wire [3:0]  pins_s;
    wire [10:0] events_s;
    wire        sclk_s;
    wire        cs_n_s;
    wire        sdi_s;
    wire        sio_s;

    pin_sync
    #(
        .WIDTH (4),
        .INIT  (4'h2)
    )
    u_pin_sync
    (
        .clk      (clk),
        .reset    (reset),
        .async_in ({sio_in, sdi, chip_select_n, sclk}),
        .sync_q   (pins_s)
    );

    assign sclk_s = pins_s[0];
    assign cs_n_s = pins_s[1];
    assign sdi_s  = pins_s[2];
    assign sio_s  = pins_s[3];

    pin_sync
    #(
        .WIDTH (11),
        .INIT  (11'h000)
    )
    u_event_sync
    (
        .clk      (clk),
        .reset    (reset),
        .async_in ({parity_error_rising, parity_error_falling,
                    sample_pattern_compare_fail, auto_pattern_compare_fail,
                    auto_pattern_compare_pass, retimer_pll_lock,
                    rx_dll_lock, rx_dll_warning, serial_frame_acknowledge,
                    fifo_one_slot_warning, fifo_two_slot_warning}),
        .sync_q   (events_s)
    );

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    reg  [7:4] mode_q;
    reg  [7:0] power_q;
    reg  [7:0] enable_low_q;
    reg  [7:0] enable_high_q;
    wire [7:0] status_low;
    wire [7:0] status_high;
    wire [7:0] mode_read;

    reg        wr_stb;
    reg  [6:0] wr_addr;
    reg  [7:0] wr_data;
    wire       soft_reset;
    wire [7:0] mode_rst;

    assign mode_rst = `RST_SERIAL_PORT_MODE;
    // low nibble reads the upper nibble in reversed order
    assign mode_read = {mode_q[7], mode_q[6], mode_q[5], mode_q[4],
                        mode_q[4], mode_q[5], mode_q[6], mode_q[7]};

    assign soft_reset = wr_stb && (wr_addr == `OFS_SERIAL_PORT_MODE)
                        && wr_data[`BIT_CONFIG_SELF_CLEAR];

    always @(posedge clk)
    begin
        if (reset || soft_reset)
        begin
            mode_q        <= mode_rst[7:4];
            power_q       <= `RST_POWER_DOWN_CONTROL;
            enable_low_q  <= `RST_IRQ_ENABLE;
            enable_high_q <= `RST_IRQ_ENABLE;
        end
        else if (wr_stb)
        begin
            case (wr_addr)
                `OFS_SERIAL_PORT_MODE:
                    mode_q <= {wr_data[7:6], 1'b0, wr_data[4]};
                `OFS_POWER_DOWN_CONTROL:
                    power_q <= wr_data;
                `OFS_IRQ_ENABLE_LOW:
                    enable_low_q <= wr_data & `MASK_ENABLE_LOW;
                `OFS_IRQ_ENABLE_HIGH:
                    enable_high_q <= wr_data & `MASK_ENABLE_HIGH;
                default:
                    power_q <= power_q;
            endcase
        end
    end

    assign three_wire_mode     = mode_q[`BIT_THREE_WIRE];
    assign lsb_first           = mode_q[`BIT_LSB_FIRST];
    assign bandgap_off         = power_q[`BIT_BANDGAP_OFF];
    assign ref_current_off     = power_q[`BIT_REF_CURRENT_OFF];
    assign bias_currents_off   = power_q[`BIT_BIAS_CURRENTS_OFF];
    assign conv_clock_path_off = power_q[`BIT_CONV_CLOCK_OFF];
    assign retimer_pll_off     = power_q[`BIT_RETIMER_PLL_OFF];
    assign rx_dll_off          = power_q[`BIT_RX_DLL_OFF];

    always @(posedge clk)
    begin
        if (reset)
            full_scale_current_out <= {CUR_WIDTH{1'b0}};
        else if (ref_current_off)
            full_scale_current_out <= {CUR_WIDTH{1'b0}};
        else
            full_scale_current_out <= full_scale_current;
    end

    // ---------------------------------------------------------------
    // event edges and sticky status
    // ---------------------------------------------------------------
    reg  [10:0] events_prev_q;
    wire [10:0] rise;
    wire [7:0]  set_low;
    wire [7:0]  set_high;
    wire [7:0]  clr_low;
    wire [7:0]  clr_high;

    always @(posedge clk)
    begin
        if (reset)
            events_prev_q <= 11'h000;
        else
            events_prev_q <= events_s;
    end

    assign rise = events_s & ~events_prev_q;

    assign set_low  = {rise[0], rise[1], rise[2], 1'b0,
                       rise[3], rise[4],
                       ~events_s[5] & events_prev_q[5], rise[5]};
    assign set_high = {1'b0, rise[6], rise[7], rise[8],
                       rise[9], rise[10], 2'b00};

    assign clr_low  = (wr_stb && wr_addr == `OFS_IRQ_STATUS_LOW)
                      ? wr_data : 8'h00;
    assign clr_high = (wr_stb && wr_addr == `OFS_IRQ_STATUS_HIGH)
                      ? wr_data : 8'h00;

    sticky_flags
    #(
        .WIDTH (8),
        .LIVE  (`MASK_STATUS_LOW)
    )
    u_status_low
    (
        .clk         (clk),
        .reset       (reset),
        .clear_all   (soft_reset),
        .set_pulse   (set_low),
        .clear_pulse (clr_low),
        .flags_q     (status_low)
    );

    sticky_flags
    #(
        .WIDTH (8),
        .LIVE  (`MASK_STATUS_HIGH)
    )
    u_status_high
    (
        .clk         (clk),
        .reset       (reset),
        .clear_all   (soft_reset),
        .set_pulse   (set_high),
        .clear_pulse (clr_high),
        .flags_q     (status_high)
    );

    always @(posedge clk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |((status_low & enable_low_q)
                     | (status_high & enable_high_q));
    end

    // ---------------------------------------------------------------
    // register read mux
    // ---------------------------------------------------------------
    function [7:0] read_reg;
        input [6:0] addr;
        begin
            case (addr)
                `OFS_SERIAL_PORT_MODE:   read_reg = mode_read;
                `OFS_POWER_DOWN_CONTROL: read_reg = power_q;
                `OFS_IRQ_ENABLE_LOW:     read_reg = enable_low_q;
                `OFS_IRQ_ENABLE_HIGH:    read_reg = enable_high_q;
                `OFS_IRQ_STATUS_LOW:     read_reg = status_low;
                `OFS_IRQ_STATUS_HIGH:    read_reg = status_high;
                default:                 read_reg = 8'h00;
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // serial frame engine
    // ---------------------------------------------------------------
    reg        sclk_prev_q;
    reg  [3:0] bit_cnt_q;
    reg  [7:0] shift_q;
    reg        read_q;
    reg  [6:0] addr_q;
    reg  [7:0] rd_byte_q;
    wire       sclk_rise;
    wire       sclk_fall;
    wire       in_bit;
    wire [7:0] shift_next;
    wire [2:0] out_idx;

    assign sclk_rise  = ~cs_n_s & sclk_s & ~sclk_prev_q;
    assign sclk_fall  = ~cs_n_s & ~sclk_s & sclk_prev_q;
    // three-wire takes data from the shared line
    assign in_bit     = three_wire_mode ? sio_s : sdi_s;
    assign shift_next = lsb_first ? {in_bit, shift_q[7:1]}
                                  : {shift_q[6:0], in_bit};
    assign out_idx    = lsb_first ? bit_cnt_q[2:0]
                                  : 3'd7 - bit_cnt_q[2:0];

    always @(posedge clk)
    begin
        if (reset)
            sclk_prev_q <= 1'b0;
        else
            sclk_prev_q <= sclk_s;
    end

    always @(posedge clk)
    begin
        wr_stb <= 1'b0;
        if (reset || cs_n_s)
        begin
            bit_cnt_q <= 4'd0;
            shift_q   <= 8'h00;
            read_q    <= 1'b0;
            addr_q    <= 7'h00;
            rd_byte_q <= 8'h00;
            wr_addr   <= 7'h00;
            wr_data   <= 8'h00;
        end
        else if (sclk_rise)
        begin
            shift_q <= shift_next;
            if (bit_cnt_q == `FRAME_LAST_INSTR_BIT)
            begin
                read_q    <= shift_next[`BIT_READ_FLAG];
                addr_q    <= shift_next[6:0];
                rd_byte_q <= read_reg(shift_next[6:0]);
                bit_cnt_q <= `FRAME_FIRST_DATA_BIT;
            end
            else if (bit_cnt_q == `FRAME_LAST_DATA_BIT)
            begin
                // streaming continues at the next address
                wr_stb    <= ~read_q;
                wr_addr   <= addr_q;
                wr_data   <= shift_next;
                addr_q    <= addr_q + 7'd1;
                rd_byte_q <= read_reg(addr_q + 7'd1);
                bit_cnt_q <= `FRAME_FIRST_DATA_BIT;
            end
            else
                bit_cnt_q <= bit_cnt_q + 4'd1;
        end
    end

    // read data changes on the falling serial clock edge
    always @(posedge clk)
    begin
        if (reset)
        begin
            sio_out <= 1'b0;
            sdo     <= 1'b0;
        end
        else if (sclk_fall && bit_cnt_q[3])
        begin
            sio_out <= rd_byte_q[out_idx];
            sdo     <= rd_byte_q[out_idx];
        end
    end

    // shared line driven only in three-wire read data phase
    assign sio_oe = ~cs_n_s & read_q & bit_cnt_q[3] & three_wire_mode;

endmodule

`default_nettype wire

// file: config_power_irq_regs_chk.sv
// port-level checker for the configuration register block
`timescale 1ns/1ps
`default_nettype none

module config_power_irq_regs_chk
#(
    parameter CUR_WIDTH = 10
)
(
    // clock and reset
    input wire logic                 clk,
    input wire logic                 reset,
    // serial port
    input wire logic                 chip_select_n,
    input wire logic                 sio_oe,
    // full-scale path
    input wire logic [CUR_WIDTH-1:0] full_scale_current,
    input wire logic [CUR_WIDTH-1:0] full_scale_current_out,
    // controls
    input wire logic                 bandgap_off,
    input wire logic                 ref_current_off,
    input wire logic                 bias_currents_off,
    input wire logic                 conv_clock_path_off,
    input wire logic                 retimer_pll_off,
    input wire logic                 rx_dll_off,
    input wire logic                 three_wire_mode,
    input wire logic                 lsb_first,
    input wire logic                 irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_mode_rst;
        $fell(reset) |-> three_wire_mode && !lsb_first;
    endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("mode after reset wrong");
    property p_power_rst;
        $fell(reset) |-> {bandgap_off, ref_current_off, bias_currents_off,
                          conv_clock_path_off, retimer_pll_off, rx_dll_off} == 6'h10;
    endproperty
    a_power_rst: assert property (p_power_rst) else $error("power after reset wrong");
    property p_irq_rst;
        $fell(reset) |-> !irq;
    endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
    property p_fsc_zero;
        ref_current_off |=> full_scale_current_out == '0;
    endproperty
    a_fsc_zero: assert property (p_fsc_zero) else $error("full scale not zero");
    property p_fsc_pass;
        !ref_current_off |=> full_scale_current_out == $past(full_scale_current);
    endproperty
    a_fsc_pass: assert property (p_fsc_pass) else $error("full scale not passed");
    property p_oe_idle;
        chip_select_n [*6] |-> !sio_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("drive outside frame");
    property p_oe_four_wire;
        !three_wire_mode |-> !sio_oe;
    endproperty
    a_oe_four_wire: assert property (p_oe_four_wire) else $error("shared drive in 4-wire");
    property p_idle_stable;
        chip_select_n [*8] |=> $stable({bandgap_off, ref_current_off, bias_currents_off,
            conv_clock_path_off, retimer_pll_off, rx_dll_off, three_wire_mode, lsb_first});
    endproperty
    a_idle_stable: assert property (p_idle_stable) else $error("control moved idle");

    c_irq: cover property ($rose(irq));
    c_oe: cover property ($rose(sio_oe));
    c_lsb: cover property ($rose(lsb_first));
endmodule

bind config_power_irq_regs config_power_irq_regs_chk #(.CUR_WIDTH(CUR_WIDTH)) i_chk (
    .clk(clk), .reset(reset), .chip_select_n(chip_select_n), .sio_oe(sio_oe),
    .full_scale_current(full_scale_current), .full_scale_current_out(full_scale_current_out),
    .bandgap_off(bandgap_off), .ref_current_off(ref_current_off),
    .bias_currents_off(bias_currents_off), .conv_clock_path_off(conv_clock_path_off),
    .retimer_pll_off(retimer_pll_off), .rx_dll_off(rx_dll_off),
    .three_wire_mode(three_wire_mode), .lsb_first(lsb_first), .irq(irq));
`default_nettype wire

// file: spi_host_model.sv
// serial host model for the configuration port
`timescale 1ns/1ps
`default_nettype none

module spi_host_model
(
    // clock
    input  wire logic clk,
    // serial pins
    output var  logic sclk,
    output var  logic chip_select_n,
    output var  logic sdi,
    output wire logic sio_in,
    input  wire logic sio_out,
    input  wire logic sio_oe,
    input  wire logic sdo
);
    logic three_wire;
    logic lsb_order;
    logic drv_q;

    initial
    begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        sdi = 1'b0;
        drv_q = 1'b0;
        three_wire = 1'b1;
        lsb_order = 1'b0;
    end

    // shared line: device drive wins while enabled
    assign sio_in = sio_oe ? sio_out : drv_q;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one bit: 80 ns low, 80 ns high, sample late in the high phase
    task automatic bit_step(input logic b, output logic s);
        sdi = three_wire ? ~b : b;
        drv_q = three_wire ? b : ~b;
        tick(4);
        sclk = 1'b1;
        tick(4);
        s = three_wire ? sio_in : sdo;
        sclk = 1'b0;
    endtask

    task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                         output logic [7:0] rdat);
        logic [7:0] ins;
        logic       s;
        ins = {rd, a};
        chip_select_n = 1'b0;
        tick(4);
        for (int i = 0; i < 8; i++)
            bit_step(ins[lsb_order ? i : 7 - i], s);
        for (int i = 0; i < 8; i++)
        begin
            bit_step(wd[lsb_order ? i : 7 - i], s);
            rdat[lsb_order ? i : 7 - i] = s;
        end
        tick(4);
        chip_select_n = 1'b1;
        tick(10);
    endtask
endmodule
`default_nettype wire

// file: config_power_irq_regs_tb.sv
// self-checking testbench for the configuration register block
`timescale 1ns/1ps
`default_nettype none

module config_power_irq_regs_tb;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       sclk, chip_select_n, sdi, sio_in, sio_out, sio_oe, sdo;
    logic [10:0] ev = '0;
    logic [9:0] fs_cur = 10'h2a5;
    logic [9:0] fs_cur_out;
    logic [5:0] pd;
    logic       three_wire_mode, lsb_first, irq;
    int         err_total = 0;
    int         checks_done = 0;

    always #10 clk = ~clk;

    config_power_irq_regs i_config_power_irq_regs (
        .clk(clk), .reset(reset), .sclk(sclk), .chip_select_n(chip_select_n),
        .sdi(sdi), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .sdo(sdo),
        .fifo_two_slot_warning(ev[0]), .fifo_one_slot_warning(ev[1]),
        .serial_frame_acknowledge(ev[2]), .rx_dll_warning(ev[3]), .rx_dll_lock(ev[4]),
        .retimer_pll_lock(ev[5]), .auto_pattern_compare_pass(ev[6]),
        .auto_pattern_compare_fail(ev[7]), .sample_pattern_compare_fail(ev[8]),
        .parity_error_falling(ev[9]), .parity_error_rising(ev[10]),
        .full_scale_current(fs_cur), .full_scale_current_out(fs_cur_out),
        .bandgap_off(pd[5]), .ref_current_off(pd[4]), .bias_currents_off(pd[3]),
        .conv_clock_path_off(pd[2]), .retimer_pll_off(pd[1]), .rx_dll_off(pd[0]),
        .three_wire_mode(three_wire_mode), .lsb_first(lsb_first), .irq(irq));

    spi_host_model i_spi_host_model (
        .clk(clk), .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi),
        .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .sdo(sdo));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_spi_host_model.frame(1'b0, a, d, x);
    endtask

    // mode write, then host follows the new wiring and order
    task automatic set_mode(input logic [7:0] d);
        wr(7'h00, d);
        i_spi_host_model.three_wire = d[7];
        i_spi_host_model.lsb_order = d[6];
    endtask

    task automatic chk_reg(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] got;
        i_spi_host_model.frame(1'b1, a, 8'h00, got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] reg %h expected %h seen %h", a, exp, got);
        end
    endtask

    task automatic chk_pin(input string nm, input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    logic [7:0] rst_tab [8] = '{8'h81, 8'h48, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    initial
    begin
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        i_spi_host_model.tick(6);
        // ------------------------------------------------
        // reset values and unmapped places
        // ------------------------------------------------
        for (int i = 0; i < 8; i++)
            chk_reg(i[6:0], rst_tab[i]);
        chk_pin("power", {4'h0, pd}, 10'h010);
        chk_pin("full scale", fs_cur_out, 10'h000);
        $display("test reset done");
        // ------------------------------------------------
        // power controls
        // ------------------------------------------------
        wr(7'h01, 8'haf);
        chk_reg(7'h01, 8'haf);
        chk_pin("power", {4'h0, pd}, 10'h02f);
        chk_pin("full scale", fs_cur_out, fs_cur);
        wr(7'h01, 8'h48);
        chk_pin("full scale", fs_cur_out, 10'h000);
        $display("test power done");
        // ------------------------------------------------
        // wiring, bit order and mirrors
        // ------------------------------------------------
        set_mode(8'h00);
        chk_reg(7'h00, 8'h00);
        chk_pin("wire", {9'h0, three_wire_mode}, 10'h000);
        set_mode(8'h42);
        chk_reg(7'h00, 8'h42);
        set_mode(8'hc0);
        chk_reg(7'h00, 8'hc3);
        chk_pin("mode", {8'h0, three_wire_mode, lsb_first}, 10'h003);
        set_mode(8'h81);
        chk_reg(7'h00, 8'h81);
        $display("test mode done");
        // ------------------------------------------------
        // events, enables, clearing
        // ------------------------------------------------
        ev = '1;
        i_spi_host_model.tick(8);
        ev = '0;
        i_spi_host_model.tick(8);
        chk_reg(7'h05, 8'hef);
        chk_reg(7'h06, 8'h7c);
        chk_pin("irq", {9'h0, irq}, 10'h000);
        wr(7'h03, 8'h01);
        chk_pin("irq", {9'h0, irq}, 10'h001);
        wr(7'h05, 8'h01);
        chk_reg(7'h05, 8'hee);
        chk_pin("irq", {9'h0, irq}, 10'h000);
        wr(7'h03, 8'hff);
        chk_reg(7'h03, 8'hef);
        chk_pin("irq", {9'h0, irq}, 10'h001);
        wr(7'h05, 8'hff);
        chk_reg(7'h05, 8'h00);
        chk_pin("irq", {9'h0, irq}, 10'h000);
        wr(7'h04, 8'hff);
        chk_reg(7'h04, 8'hfc);
        chk_pin("irq", {9'h0, irq}, 10'h001);
        wr(7'h06, 8'hff);
        chk_reg(7'h06, 8'h00);
        chk_pin("irq", {9'h0, irq}, 10'h000);
        $display("test events done");
        // ------------------------------------------------
        // self-clearing configuration reset
        // ------------------------------------------------
        wr(7'h01, 8'haf);
        wr(7'h03, 8'hff);
        wr(7'h00, 8'ha0);
        chk_reg(7'h00, 8'h81);
        chk_reg(7'h01, 8'h48);
        chk_reg(7'h03, 8'h00);
        chk_pin("power", {4'h0, pd}, 10'h010);
        $display("test soft reset done");
        give_verdict();
    end

    initial
    begin
        #400000;
        err_total++;
        $display("[FAIL] watchdog expected end seen timeout");
        give_verdict();
    end
endmodule
`default_nettype wire
